// [rtl/smri_regs.vh]
`ifndef SMRI_REGS_VH
`define SMRI_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SMRI_ADDR_CTRL      8'h84
`define SMRI_ADDR_STAT      8'h86
`define SMRI_ADDR_SEL       8'h88
`define SMRI_ADDR_TXB       8'h8A
`define SMRI_ADDR_RXB       8'h8E
// ----------------------------------------
// Control fields
// ----------------------------------------
`define SMRI_CTRL_EN        7
`define SMRI_CTRL_IEN       6
`define SMRI_CTRL_START     5
`define SMRI_CTRL_DIV_HI    4
`define SMRI_CTRL_DIV_LO    3
`define SMRI_CTRL_PHA       2
`define SMRI_CTRL_POL       1
`define SMRI_CTRL_RSE       0
// ----------------------------------------
// Status fields
// ----------------------------------------
`define SMRI_STAT_DONE      7
`define SMRI_STAT_ERR       6
`define SMRI_STAT_BUSY      5
`define SMRI_STAT_INTN      4
`define SMRI_STAT_TXE       3
`define SMRI_STAT_RXF       2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMRI_CTRL_RST       8'h00
`define SMRI_SEL_RST        8'h00
`define SMRI_DATA_RST       8'h00
// ----------------------------------------
// Timing: half-period counts per divider code
// ----------------------------------------
`define SMRI_HALF_DIV4      5'h01
`define SMRI_HALF_DIV8      5'h03
`define SMRI_HALF_DIV16     5'h07
`define SMRI_HALF_DIV32     5'h0F
`define SMRI_BITS_PER_BYTE  4'h8
`endif

// [rtl/smri_serial_clock_divider.v]
`timescale 1ns/1ps
`include "smri_regs.vh"
module smri_serial_clock_divider (
	input  wire       i_clk,
	input  wire       i_rst_n,
	input  wire       i_run,
	input  wire [1:0] i_div,
	output reg        o_sck_ff,
	output reg        o_rise_ff,
	output reg        o_fall_ff
);
	reg  [4:0] cnt_ff;
	reg  [4:0] half;

	always @* begin
		case (i_div)
		2'b00: half = `SMRI_HALF_DIV4;
		2'b01: half = `SMRI_HALF_DIV8;
		2'b10: half = `SMRI_HALF_DIV16;
		default: half = `SMRI_HALF_DIV32;
		endcase
	end

	// Gated by i_run (held low while it is low), 50 percent duty internal clock
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff    <= 5'h00;
			o_sck_ff  <= 1'b0;
			o_rise_ff <= 1'b0;
			o_fall_ff <= 1'b0;
		end else if (!i_run) begin
			cnt_ff    <= 5'h00;
			o_sck_ff  <= 1'b0;
			o_rise_ff <= 1'b0;
			o_fall_ff <= 1'b0;
		end else if (cnt_ff >= half) begin
			cnt_ff    <= 5'h00;
			o_sck_ff  <= ~o_sck_ff;
			o_rise_ff <= ~o_sck_ff;
			o_fall_ff <= o_sck_ff;
		end else begin
			cnt_ff    <= cnt_ff + 5'h01;
			o_rise_ff <= 1'b0;
			o_fall_ff <= 1'b0;
		end
	end
endmodule // smri_serial_clock_divider

// [rtl/smri_top.v]
// Functional notes
// - Enable bit low holds the sequencer and its flags in reset, transmit empty aside; high lets it run.
// - Interrupt enable gates the request only; the pending cause stays.
// - Start set with transmit buffer full begins shifting out.
// - While start stays set, bytes keep flowing and each is received.
// - Divider code 00/01/10/11 gives clock divide by 4/8/16/32.
// - Phase 0 data valid on first edge, phase 1 on second edge.
// - Polarity sets idle level of the serial clock, low or high.
// - Sample bit 0 captures on falling edge, 1 on rising edge.
// - Each set mask bit asserts its select line during transfers.
// - Several set mask bits assert all their select lines together.
// - Moving buffer into shift register sets the transmit empty flag.
// - Host write of the transmit buffer clears the empty flag.
// - Shifting starts only with empty flag clear and start set.
// - A whole received byte moved to the buffer sets receive full.
// - Host read of the receive buffer clears receive full.
// - Receive buffer holds its byte through the next whole transfer.
// - Interrupt flag low on empty with start, full without start, error.
`timescale 1ns/1ps
`include "smri_regs.vh"
module smri_top (
	input  wire       I_REF_CLK,
	input  wire       I_RSTN,
	input  wire [7:0] I_ADDR,
	input  wire [7:0] I_WDATA,
	input  wire       I_WR,
	input  wire       I_RD,
	output reg  [7:0] O_RDATA,
	output reg        O_IRQ_N,
	output reg        O_SCK,
	output reg        O_SCK_OE,
	output reg        O_MOSI,
	output reg        O_MOSI_OE,
	input  wire       I_MISO,
	input  wire       I_SS_IN_N,
	output reg  [7:0] O_SS_N,
	output reg        O_SS_OE,
	output reg        O_TX_EMPTY,
	output reg        O_RX_FULL
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_SS1   = 4'h1;
	localparam [3:0] ST_SS2   = 4'h2;
	localparam [3:0] ST_LOAD  = 4'h3;
	localparam [3:0] ST_XFER  = 4'h4;
	localparam [3:0] ST_DONE  = 4'h5;
	localparam [3:0] ST_CHK   = 4'h6;
	localparam [3:0] ST_HOLD1 = 4'h7;
	localparam [3:0] ST_HOLD2 = 4'h8;
	localparam [3:0] ST_NEG   = 4'h9;

	reg  [7:0] ctrl_ff;
	reg  [7:0] sel_ff;
	reg  [7:0] txb_ff;
	reg  [7:0] rxb_ff;
	reg  [7:0] txsh_ff;
	reg  [7:0] rxsh_ff;
	reg  [3:0] state_ff;
	reg  [3:0] bits_ff;
	reg        txe_ff;
	reg        rxf_ff;
	reg        err_ff;
	reg        done_ff;
	reg        ssn_ff;
	reg        sck_on_ff;
	reg        ph0_ff;
	reg        nxt_txe;
	reg        nxt_rxf;
	reg        nxt_err;
	wire       sck_int;
	wire       rise;
	wire       fall;
	wire       en         = ctrl_ff[`SMRI_CTRL_EN];
	wire       start      = ctrl_ff[`SMRI_CTRL_START];
	wire       pha        = ctrl_ff[`SMRI_CTRL_PHA];
	wire       pol        = ctrl_ff[`SMRI_CTRL_POL];
	wire       rse        = ctrl_ff[`SMRI_CTRL_RSE];
	wire       wr_txb     = I_WR && (I_ADDR == `SMRI_ADDR_TXB);
	wire       rd_rxb     = I_RD && (I_ADDR == `SMRI_ADDR_RXB);
	wire       wr_stat    = I_WR && (I_ADDR == `SMRI_ADDR_STAT);
	wire       run        = en && !err_ff;
	// External clock seen by the slave, and its edges before polarity
	wire       sck_ext    = (pha ? ~sck_int : sck_int) ^ pol;
	wire       ext_rise   = pha ? fall : rise;
	wire       ext_fall   = pha ? rise : fall;
	// Shift on every internal clock fall after a byte's first sample, whatever the phase, polarity and sample settings
	wire       shift_edge = fall;
	// Phase 0 clock waits a low half so its first pulse is whole
	wire       sck_live   = pha || ph0_ff;
	wire       samp_edge  = sck_live &&
	                        (rse ? (pol ? ext_fall : ext_rise)
	                             : (pol ? ext_rise : ext_fall));
	wire       load_rx;
	wire       cont_load;
	wire       int_cause;
	wire [7:0] status;

	smri_serial_clock_divider u_div (
		.i_clk     (I_REF_CLK),
		.i_rst_n   (I_RSTN),
		.i_run     (run),
		.i_div     (ctrl_ff[`SMRI_CTRL_DIV_HI:`SMRI_CTRL_DIV_LO]),
		.o_sck_ff  (sck_int),
		.o_rise_ff (rise),
		.o_fall_ff (fall)
	);

	// ----------------------------------------
	// Host registers
	// ----------------------------------------
	always @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_ff <= `SMRI_CTRL_RST;
			sel_ff  <= `SMRI_SEL_RST;
			txb_ff  <= `SMRI_DATA_RST;
		end else if (I_WR) begin
			if (I_ADDR == `SMRI_ADDR_CTRL) begin
				ctrl_ff <= I_WDATA;
			end else if (I_ADDR == `SMRI_ADDR_SEL) begin
				sel_ff <= I_WDATA;
			end else if (I_ADDR == `SMRI_ADDR_TXB) begin
				txb_ff <= I_WDATA;
			end
		end
	end

	assign load_rx = (state_ff == ST_XFER) && samp_edge &&
	                 (bits_ff == `SMRI_BITS_PER_BYTE - 4'h1);
	// Phase 1 back-to-back: reload on the last sample, no clock gap
	assign cont_load = load_rx && pha && start && !txe_ff;
	assign int_cause = (txe_ff && start) || (rxf_ff && !start) || err_ff;
	assign status = {done_ff, err_ff, ~ssn_ff, ~int_cause,
	                 txe_ff, rxf_ff, 2'b00};

	// ----------------------------------------
	// Flags: hardware set wins over host clear
	// ----------------------------------------
	always @* begin
		nxt_txe = txe_ff;
		if (wr_txb) begin
			nxt_txe = 1'b0;
		end
		if (run && ((state_ff == ST_LOAD && rise) || cont_load)) begin
			nxt_txe = 1'b1;
		end
		nxt_rxf = rxf_ff;
		if (rd_rxb) begin
			nxt_rxf = 1'b0;
		end
		if (run && load_rx) begin
			nxt_rxf = 1'b1;
		end
		nxt_err = err_ff;
		if (wr_stat && !I_WDATA[`SMRI_STAT_ERR]) begin
			nxt_err = 1'b0;
		end
		if (en && !I_SS_IN_N) begin
			nxt_err = 1'b1;
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	always @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_ff  <= ST_IDLE;
			bits_ff   <= 4'h0;
			txsh_ff   <= 8'h00;
			rxsh_ff   <= 8'h00;
			rxb_ff    <= 8'h00;
			txe_ff    <= 1'b1;
			rxf_ff    <= 1'b0;
			err_ff    <= 1'b0;
			done_ff   <= 1'b0;
			ssn_ff    <= 1'b1;
			sck_on_ff <= 1'b0;
			ph0_ff    <= 1'b0;
		end else if (!en) begin
			state_ff  <= ST_IDLE;
			bits_ff   <= 4'h0;
			ph0_ff    <= 1'b0;
			txe_ff    <= nxt_txe;
			rxf_ff    <= 1'b0;
			err_ff    <= 1'b0;
			done_ff   <= 1'b0;
			ssn_ff    <= 1'b1;
			sck_on_ff <= 1'b0;
		end else begin
			txe_ff <= nxt_txe;
			rxf_ff <= nxt_rxf;
			err_ff <= nxt_err;
			if (nxt_err) begin
				state_ff  <= ST_IDLE;
				ssn_ff    <= 1'b1;
				sck_on_ff <= 1'b0;
				ph0_ff    <= 1'b0;
			end else begin
				if (state_ff == ST_XFER && samp_edge) begin
					rxsh_ff <= {rxsh_ff[6:0], I_MISO};
				end
				if (load_rx) begin
					rxb_ff <= {rxsh_ff[6:0], I_MISO};
				end
				case (state_ff)
				ST_IDLE: begin
					if (start && !txe_ff && fall) begin
						state_ff <= ST_SS1;
						ssn_ff   <= 1'b0;
						done_ff  <= 1'b0;
					end
				end
				ST_SS1: if (rise) begin
					state_ff <= ST_SS2;
				end
				ST_SS2: if (fall) begin
					state_ff <= ST_LOAD;
				end
				ST_LOAD: if (rise) begin
					txsh_ff   <= txb_ff;
					bits_ff   <= 4'h0;
					done_ff   <= 1'b0;
					sck_on_ff <= 1'b1;
					ph0_ff    <= 1'b0;
					state_ff  <= ST_XFER;
				end
				ST_XFER: begin
					if (samp_edge) begin
						bits_ff <= bits_ff + 4'h1;
					end
					if (fall) begin
						ph0_ff <= 1'b1;
					end
					if (shift_edge && bits_ff != 4'h0) begin
						txsh_ff <= {txsh_ff[6:0], 1'b0};
					end
					if (cont_load) begin
						txsh_ff <= txb_ff;
						bits_ff <= 4'h0;
					end else if (load_rx) begin
						// Mask only at idle level: no stray edge
						if (sck_ext == pol) begin
							sck_on_ff <= 1'b0;
						end
						state_ff <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (sck_ext == pol) begin
						sck_on_ff <= 1'b0;
					end
					if (fall) begin
						done_ff  <= 1'b1;
						state_ff <= ST_CHK;
					end
				end
				ST_CHK: if (fall) begin
					sck_on_ff <= 1'b0;
					state_ff  <= ST_HOLD1;
				end
				ST_HOLD1: if (fall) begin
					state_ff <= ST_HOLD2;
				end
				ST_HOLD2: if (fall) begin
					ssn_ff   <= 1'b1;
					state_ff <= ST_NEG;
				end
				ST_NEG: if (fall) begin
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA    <= 8'h00;
			O_IRQ_N    <= 1'b1;
			O_SCK      <= 1'b0;
			O_SCK_OE   <= 1'b0;
			O_MOSI     <= 1'b0;
			O_MOSI_OE  <= 1'b0;
			O_SS_N     <= 8'hFF;
			O_SS_OE    <= 1'b0;
			O_TX_EMPTY <= 1'b1;
			O_RX_FULL  <= 1'b0;
		end else begin
			if (I_ADDR == `SMRI_ADDR_CTRL) begin
				O_RDATA <= ctrl_ff;
			end else if (I_ADDR == `SMRI_ADDR_STAT) begin
				O_RDATA <= status;
			end else if (I_ADDR == `SMRI_ADDR_SEL) begin
				O_RDATA <= sel_ff;
			end else if (I_ADDR == `SMRI_ADDR_TXB) begin
				O_RDATA <= txb_ff;
			end else if (I_ADDR == `SMRI_ADDR_RXB) begin
				O_RDATA <= rxb_ff;
			end else begin
				O_RDATA <= 8'h00;
			end
			O_IRQ_N   <= ~(en && ctrl_ff[`SMRI_CTRL_IEN] && int_cause);
			O_SCK     <= (sck_on_ff && sck_live) ? sck_ext : pol;
			O_SCK_OE  <= run;
			O_MOSI    <= txsh_ff[7];
			O_MOSI_OE <= run;
			O_SS_N    <= ~(sel_ff & {8{~ssn_ff}});
			O_SS_OE   <= run;
			O_TX_EMPTY <= txe_ff;
			O_RX_FULL  <= rxf_ff;
		end
	end
endmodule // smri_top

// [tb/smri_sva.sv]
`timescale 1ns/1ps
`include "smri_regs.vh"
module smri_sva (
	input wire       I_REF_CLK,
	input wire       I_RSTN,
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire       I_WR,
	input wire       I_RD,
	input wire       O_IRQ_N,
	input wire       O_SCK,
	input wire       O_SCK_OE,
	input wire [7:0] O_SS_N,
	input wire       O_TX_EMPTY,
	input wire       O_RX_FULL
);
	reg  [7:0] ctl_ff;
	reg  [7:0] sel_ff;
	reg  [7:0] run_ff;
	reg        sck_ff;
	reg        seen_ff;
	wire       tog  = O_SCK != sck_ff;
	wire       idle = O_SS_N == 8'hFF;
	wire [7:0] half = 8'h02 << ctl_ff[4:3];
	// Toggle spacing judged only inside a frame; idle level moves are free
	always @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctl_ff  <= 8'h00;
			sel_ff  <= 8'h00;
			run_ff  <= 8'h00;
			sck_ff  <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			if (I_WR && I_ADDR == `SMRI_ADDR_CTRL)
				ctl_ff <= I_WDATA;
			if (I_WR && I_ADDR == `SMRI_ADDR_SEL)
				sel_ff <= I_WDATA;
			run_ff  <= tog ? 8'h01 : run_ff + 8'h01;
			sck_ff  <= O_SCK;
			seen_ff <= !idle && (seen_ff || tog);
		end
	end
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);
	sequence s_ss_fall;
		$past(idle) && !idle;
	endsequence
	sequence s_idle_cfg;
		idle && ctl_ff[7] && $past(ctl_ff, 3) == ctl_ff;
	endsequence
	property p_tx_clr;
		I_WR && I_ADDR == `SMRI_ADDR_TXB |-> ##[1:2] !O_TX_EMPTY;
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx flag kept");
	property p_rx_clr;
		I_RD && I_ADDR == `SMRI_ADDR_RXB |-> ##[1:2] !O_RX_FULL;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("rx flag kept");
	property p_idle;
		s_idle_cfg |-> O_SCK == ctl_ff[1];
	endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_sel_off;
		(O_SS_N | sel_ff) == 8'hFF;
	endproperty
	a_sel_off: assert property (p_sel_off) else $error("stray select");
	property p_sel_all;
		idle || O_SS_N == ~sel_ff;
	endproperty
	a_sel_all: assert property (p_sel_all) else $error("select set");
	property p_div;
		tog && seen_ff && !idle |-> run_ff % half == 8'h00;
	endproperty
	a_div: assert property (p_div) else $error("clock rate");
	property p_start;
		s_ss_fall |-> ctl_ff[5] && !$past(O_TX_EMPTY);
	endproperty
	a_start: assert property (p_start) else $error("early frame");
	property p_txe_set;
		$rose(O_TX_EMPTY) |-> !idle;
	endproperty
	a_txe_set: assert property (p_txe_set) else $error("tx flag set");
	property p_dis;
		!ctl_ff[7] [*3] |-> idle && !O_RX_FULL && !O_SCK_OE;
	endproperty
	a_dis: assert property (p_dis) else $error("runs disabled");
	property p_ien;
		!ctl_ff[6] [*3] |-> O_IRQ_N;
	endproperty
	a_ien: assert property (p_ien) else $error("masked request");
endmodule // smri_sva
bind smri_top smri_sva u_smri_sva (
	.I_REF_CLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_IRQ_N,
	.O_SCK, .O_SCK_OE, .O_SS_N, .O_TX_EMPTY, .O_RX_FULL
);

// [tb/smri_slave.sv]
`timescale 1ns/1ps
module smri_slave (
	input  wire       i_sck,
	input  wire       i_ss_n,
	input  wire       i_mosi,
	input  wire       i_pha,
	input  wire       i_pol,
	input  wire [7:0] i_tx,
	output reg        o_miso,
	output reg  [7:0] o_rx
);
	reg [7:0] sh_ff;
	reg [3:0] cnt_ff;
	initial o_miso = 1'b0;
	always @(negedge i_ss_n) begin
		sh_ff  = i_tx;
		cnt_ff = 4'h0;
		if (!i_pha) begin
			o_miso = sh_ff[7];
			sh_ff  = sh_ff << 1;
		end
	end
	// Released line floats; inverse stops a stale bit passing as data
	always @(posedge i_ss_n) o_miso = ~o_miso;
	always @(i_sck) begin
		if (!i_ss_n && (i_sck ^ i_pol ^ i_pha)) begin
			o_rx   = {o_rx[6:0], i_mosi};
			cnt_ff = cnt_ff + 4'h1;
			if (cnt_ff == 4'h8) begin
				cnt_ff = 4'h0;
				sh_ff  = i_tx;
			end
		end else if (!i_ss_n) begin
			o_miso = sh_ff[7];
			sh_ff  = sh_ff << 1;
		end
	end
endmodule // smri_slave

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "smri_regs.vh"
module testbench;
	reg        ref_clk = 1'b0;
	reg        rst_n   = 1'b0;
	reg  [7:0] addr    = 8'h00;
	reg  [7:0] wdata   = 8'h00;
	reg        wr_s    = 1'b0;
	reg        rd_s    = 1'b0;
	reg        ss_in_n = 1'b1;
	reg        s_pha   = 1'b0;
	reg        s_pol   = 1'b0;
	reg  [7:0] s_tx    = 8'h00;
	reg  [7:0] c, mt, st;
	reg  [1:0] m;
	integer    i;
	integer    bad_count = 0;
	integer    samples_checked = 0;
	wire [7:0] rdata, ss_n, s_rx;
	wire       irq_n, sck, mosi, miso, txe, rxf;
	wire [3:0] flg = {&ss_n, irq_n, rxf, txe};
	always #5 ref_clk = ~ref_clk;
	smri_top u_smri_top (.I_REF_CLK(ref_clk), .I_RSTN(rst_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
		.O_IRQ_N(irq_n), .O_SCK(sck), .O_SCK_OE(), .O_MOSI(mosi),
		.O_MOSI_OE(), .I_MISO(miso), .I_SS_IN_N(ss_in_n), .O_SS_N(ss_n),
		.O_SS_OE(), .O_TX_EMPTY(txe), .O_RX_FULL(rxf));
	smri_slave u_smri_slave (.i_sck(sck), .i_ss_n(ss_n[0]), .i_mosi(mosi),
		.i_pha(s_pha), .i_pol(s_pol), .i_tx(s_tx), .o_miso(miso), .o_rx(s_rx));
	// ----
	// Host access, checks and run end
	// ----
	task complete_run;
	begin
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("mismatch %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task reg_wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge ref_clk);
		addr  = a;
		wdata = d;
		wr_s  = 1'b1;
		@(negedge ref_clk);
		wr_s  = 1'b0;
	end
	endtask
	task reg_rd(input [7:0] a, input [7:0] e, input [47:0] nm);
	begin
		@(negedge ref_clk);
		addr = a;
		rd_s = 1'b1;
		@(negedge ref_clk);
		rd_s = 1'b0;
		chk(nm, e, rdata);
	end
	endtask
	task wait_flag(input [1:0] s, input v, input [47:0] nm);
		integer n;
	begin
		n = 0;
		while (flg[s] !== v && n < 4000) begin
			@(negedge ref_clk);
			n = n + 1;
		end
		chk(nm, {7'h00, v}, {7'h00, flg[s]});
		if (n == 4000)
			complete_run;
	end
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		reg_rd(`SMRI_ADDR_CTRL, 8'h00, "ctrl");
		reg_rd(`SMRI_ADDR_SEL, 8'h00, "sel");
		reg_rd(8'h80, 8'h00, "unmap");
		reg_wr(`SMRI_ADDR_SEL, 8'h5A);
		reg_rd(`SMRI_ADDR_SEL, 8'h5A, "sel");
		for (i = 0; i < 4; i = i + 1) begin
			m     = i[1:0];
			s_pha = m[1];
			s_pol = m[0];
			c     = {3'h6, m, m[1], m[0], ~^m};
			mt    = 8'h96 ^ {4{m}};
			st    = 8'h5A ^ {4{m}};
			s_tx  = st;
			reg_wr(`SMRI_ADDR_SEL, 8'h01);
			reg_wr(`SMRI_ADDR_CTRL, c);
			reg_wr(`SMRI_ADDR_TXB, mt);
			reg_wr(`SMRI_ADDR_CTRL, c | 8'h20);
			wait_flag(2'h0, 1'b1, "txe");
			reg_wr(`SMRI_ADDR_CTRL, c);
			wait_flag(2'h1, 1'b1, "rxf");
			wait_flag(2'h2, 1'b0, "irq");
			chk("slave", mt, s_rx);
			reg_rd(`SMRI_ADDR_RXB, st, "rxb");
			wait_flag(2'h1, 1'b0, "rxf");
			wait_flag(2'h3, 1'b1, "idle");
		end
		s_pha = 1'b1;
		s_pol = 1'b0;
		s_tx  = 8'h11;
		reg_wr(`SMRI_ADDR_SEL, 8'h03);
		reg_wr(`SMRI_ADDR_CTRL, 8'h84);
		reg_wr(`SMRI_ADDR_TXB, 8'hE7);
		reg_wr(`SMRI_ADDR_CTRL, 8'hA4);
		wait_flag(2'h0, 1'b1, "txe");
		s_tx = 8'h22;
		reg_wr(`SMRI_ADDR_TXB, 8'h18);
		wait_flag(2'h0, 1'b0, "txe");
		wait_flag(2'h0, 1'b1, "txe");
		reg_wr(`SMRI_ADDR_CTRL, 8'h84);
		reg_rd(`SMRI_ADDR_RXB, 8'h11, "rxb");
		wait_flag(2'h1, 1'b0, "rxf");
		wait_flag(2'h1, 1'b1, "rxf");
		chk("irq", 8'h01, {7'h00, irq_n});
		reg_wr(`SMRI_ADDR_CTRL, 8'hC4);
		wait_flag(2'h2, 1'b0, "irq");
		reg_rd(`SMRI_ADDR_RXB, 8'h22, "rxb");
		chk("slave", 8'h18, s_rx);
		wait_flag(2'h3, 1'b1, "idle");
		chk("irq", 8'h01, {7'h00, irq_n});
		@(negedge ref_clk);
		ss_in_n = 1'b0;
		@(negedge ref_clk);
		ss_in_n = 1'b1;
		wait_flag(2'h2, 1'b0, "irq");
		reg_wr(`SMRI_ADDR_STAT, 8'h00);
		wait_flag(2'h2, 1'b1, "irq");
		reg_wr(`SMRI_ADDR_CTRL, 8'h00);
		reg_rd(`SMRI_ADDR_CTRL, 8'h00, "ctrl");
		complete_run;
	end
endmodule // testbench
